// *** spm_pkg.sv ***
// Shared constants and types for the super-rate performance monitor
package spm_pkg;
	// ****************************************************************
	// Timing
	// ****************************************************************
	localparam int CLK_HZ       = 20_000_000;
	localparam int LOF_SET_MS   = 2500;
	localparam int LOF_CLR_MS   = 1000;
	localparam int LOF_SET_CYC  = LOF_SET_MS * (CLK_HZ / 1000);
	localparam int LOF_CLR_CYC  = LOF_CLR_MS * (CLK_HZ / 1000);
	localparam int SEC_PER_HOUR = 3600;
	localparam int SEC_PER_QTR  = 900;
	localparam int HIST_HOURS   = 24;
	localparam int UAS_RUN      = 10;
	localparam int SES_RATIO    = 1000;
	localparam int MON_KBPS     = 8;
	localparam int RATE64_KBPS  = 64;
	localparam int RATE56_KBPS  = 56;

	// ****************************************************************
	// Widths and register map
	// ****************************************************************
	localparam int CNT_W   = 12;
	localparam int NFIELD  = 6;
	localparam int F_STAT  = 6;
	localparam int ACC_W   = 24;
	localparam logic [11:0] OFS_CTRL   = 12'h000;
	localparam logic [11:0] OFS_STAT   = 12'h004;
	localparam logic [11:0] OFS_RATE   = 12'h008;
	localparam logic [1:0]  RGN_LOCAL  = 2'h1;
	localparam logic [1:0]  RGN_REMOTE = 2'h2;
	localparam int CTRL_PERF  = 0;
	localparam int CTRL_VIEW  = 1;
	localparam int CTRL_CLR   = 2;
	localparam int CTRL_R56   = 3;
	localparam int CTRL_NLO   = 4;
	localparam int CTRL_NHI   = 8;
	localparam logic [4:0] NCHAN_RST = 5'h01;

	typedef enum logic [1:0] {
		SPM_CODE_NONE = 2'h0,
		SPM_CODE_TEST = 2'h1,
		SPM_CODE_SYNC = 2'h2,
		SPM_CODE_EXC  = 2'h3
	} spm_code_t;

	// Bit order is also the field index and the monitor byte layout
	typedef struct packed {
		logic errored_second;
		logic unavailable_second;
		logic severe_error_second;
		logic bursty_error_second;
		logic packet_loss_second;
		logic frame_loss;
	} spm_inc_t;
endpackage

// *** spm_bank_if.sv ***
// Interface between the monitor core and one counter set
`timescale 1ns/100ps
interface spm_bank_if;
	import spm_pkg::*;
	logic             tick;
	logic             hour_end;
	logic             clr;
	spm_inc_t         inc;
	spm_code_t        code;
	logic [1:0]       qtr;
	logic [4:0]       rd_hour;
	logic [2:0]       rd_field;
	logic [CNT_W-1:0] rd_data;
	modport ctrl (output tick, hour_end, clr, inc, code, qtr,
		rd_hour, rd_field, input rd_data);
	modport bank (input tick, hour_end, clr, inc, code, qtr,
		rd_hour, rd_field, output rd_data);
endinterface

// *** spm_counter_bank.sv ***
// One counter set: current hour plus 24 hours of history
`timescale 1ns/100ps
module spm_counter_bank (
	input wire logic clk_sys_in,
	input wire logic rst_n_in,
	spm_bank_if.bank bus
);
	import spm_pkg::*;

	typedef struct packed {
		logic [HIST_HOURS:0][NFIELD-1:0][CNT_W-1:0] cnt;
		logic [HIST_HOURS:0][3:0][1:0]              stat;
	} spm_bank_t;

	spm_bank_t s;
	spm_bank_t next_s;

	always_comb begin
		next_s = s;
		// Clear first so a result landing in the same cycle survives
		if (bus.clr) begin
			next_s = '0;
		end
		if (bus.tick) begin
			for (int f = 0; f < NFIELD; f++) begin
				next_s.cnt[0][f] = next_s.cnt[0][f] +
					CNT_W'(bus.inc[f]);
			end
			if (bus.code != SPM_CODE_NONE &&
				next_s.stat[0][bus.qtr] == SPM_CODE_NONE) begin
				next_s.stat[0][bus.qtr] = bus.code;
			end
			if (bus.hour_end) begin
				for (int h = HIST_HOURS; h > 0; h--) begin
					next_s.cnt[h]  = next_s.cnt[h-1];
					next_s.stat[h] = next_s.stat[h-1];
				end
				next_s.cnt[0]  = '0;
				next_s.stat[0] = '0;
			end
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	always_comb begin
		bus.rd_data = '0;
		if (bus.rd_hour <= 5'(HIST_HOURS)) begin
			if (bus.rd_field == 3'(F_STAT)) begin
				bus.rd_data = CNT_W'(s.stat[bus.rd_hour]);
			end else if (bus.rd_field < 3'(NFIELD)) begin
				bus.rd_data = s.cnt[bus.rd_hour][bus.rd_field];
			end
		end
	end
endmodule // spm_counter_bank

// *** spm_lof_detect.sv ***
// Frame loss timer: declares after a long loss, clears after a clean run
`timescale 1ns/100ps
module spm_lof_detect #(
	parameter int SET_CYC = 50_000_000,
	parameter int CLR_CYC = 20_000_000
) (
	input  wire logic clk_sys_in,
	input  wire logic rst_n_in,
	input  wire logic loss_in,
	output logic      frame_loss_out,
	output logic      declare_out
);
	localparam int CW = $clog2(SET_CYC + CLR_CYC + 1);

	typedef enum logic {
		SPM_LOF_CLEAR = 1'b0,
		SPM_LOF_DECL  = 1'b1
	} spm_lof_st_t;

	typedef struct packed {
		spm_lof_st_t   st;
		logic [CW-1:0] cnt;
		logic          decl;
	} spm_lof_t;

	spm_lof_t s;
	spm_lof_t next_s;

	always_comb begin
		next_s = s;
		next_s.decl = 1'b0;
		case (s.st)
			SPM_LOF_CLEAR: begin
				if (!loss_in) begin
					next_s.cnt = '0;
				end else if (s.cnt == CW'(SET_CYC - 1)) begin
					next_s.st   = SPM_LOF_DECL;
					next_s.cnt  = '0;
					next_s.decl = 1'b1;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
			SPM_LOF_DECL: begin
				if (loss_in) begin
					next_s.cnt = '0;
				end else if (s.cnt == CW'(CLR_CYC - 1)) begin
					next_s.st  = SPM_LOF_CLEAR;
					next_s.cnt = '0;
				end else begin
					next_s.cnt = s.cnt + 1'b1;
				end
			end
			default: begin
				next_s = '0;
			end
		endcase
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign frame_loss_out = (s.st == SPM_LOF_DECL);
	assign declare_out    = s.decl;
endmodule // spm_lof_detect

// *** spm_monitor.sv ***
// Per-port end-to-end performance monitor core with register port
`timescale 1ns/100ps
module spm_monitor #(
	parameter int LOF_SET = spm_pkg::LOF_SET_CYC,
	parameter int LOF_CLR = spm_pkg::LOF_CLR_CYC
) (
	input  wire logic        clk_sys_in,
	input  wire logic        rst_n_in,
	input  wire logic        sec_tick_in,
	input  wire logic        loopback_in,
	input  wire logic        crc_err_in,
	input  wire logic        bit_valid_in,
	input  wire logic        bit_err_in,
	input  wire logic        sync_loss_in,
	input  wire logic        out_of_frame_in,
	input  wire logic        rx_mon_valid_in,
	input  wire logic [7:0]  rx_mon_data_in,
	input  wire logic [11:0] reg_addr_in,
	input  wire logic [31:0] reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [31:0] reg_rdata_out,
	output logic             tx_mon_valid_out,
	output logic      [7:0]  tx_mon_data_out,
	output logic             perf_active_out,
	output logic      [15:0] user_rate_kbps_out,
	output logic             unavailable_out,
	output logic             frame_loss_out
);
	import spm_pkg::*;

	// ****************************************************************
	// State
	// ****************************************************************
	typedef enum logic {
		SPM_AVAIL   = 1'b0,
		SPM_UNAVAIL = 1'b1
	} spm_avail_t;

	typedef struct packed {
		logic             perf;
		logic             view_rem;
		logic             rate56;
		logic [4:0]       nchan;
		logic             clr_loc;
		logic             clr_rem;
		logic [11:0]      sec;
		logic             crc_seen;
		logic [ACC_W-1:0] bits;
		logic [ACC_W-1:0] errs;
		logic             lof_seen;
		logic             sync_seen;
		logic             loop_seen;
		logic             rx_seen;
		logic [7:0]       rx_byte;
		logic             peer;
		spm_avail_t       av;
		logic [3:0]       run;
		logic [31:0]      rdata;
		logic             tx_v;
		logic [7:0]       tx_d;
		logic [15:0]      rate;
	} spm_top_t;

	spm_top_t s;
	spm_top_t next_s;

	spm_bank_if loc_if ();
	spm_bank_if rem_if ();

	logic       lof_level;
	logic       lof_decl;
	logic       tick;
	logic       hour_end;
	logic       severe;
	logic       uas_now;
	spm_inc_t   loc_inc;
	spm_inc_t   rem_inc;
	spm_code_t  loc_code;
	logic [1:0] qtr;
	logic [15:0] gross;

	// ****************************************************************
	// Decoders
	// ****************************************************************
	function automatic logic [1:0] qtr_of(input logic [11:0] sec);
		qtr_of = 2'(sec / 12'(SEC_PER_QTR));
	endfunction

	function automatic logic is_ctrl(input logic [11:0] a);
		is_ctrl = (a == OFS_CTRL);
	endfunction

	// Both counter sets decode the same hour and field
	function automatic logic [4:0] hour_of(input logic [11:0] a);
		hour_of = a[9:5];
	endfunction

	function automatic logic [2:0] field_of(input logic [11:0] a);
		field_of = a[4:2];
	endfunction

	// ****************************************************************
	// Frame loss timer
	// ****************************************************************
	// Either loss condition keeps the one timer running
	spm_lof_detect #(
		.SET_CYC (LOF_SET),
		.CLR_CYC (LOF_CLR)
	) u_lof (
		.clk_sys_in     (clk_sys_in),
		.rst_n_in       (rst_n_in),
		.loss_in        (sync_loss_in | out_of_frame_in),
		.frame_loss_out (lof_level),
		.declare_out    (lof_decl)
	);

	// ****************************************************************
	// Counter sets
	// ****************************************************************
	spm_counter_bank u_loc (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.bus        (loc_if.bank)
	);

	spm_counter_bank u_rem (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.bus        (rem_if.bank)
	);

	// ****************************************************************
	// Per-second classification
	// ****************************************************************
	// Monitoring only runs while the reserved channel exists
	assign tick     = sec_tick_in & s.perf;
	assign hour_end = (s.sec == 12'(SEC_PER_HOUR - 1));
	assign qtr      = qtr_of(s.sec);
	assign uas_now  = (s.av == SPM_UNAVAIL);

	always_comb begin
		// Multiply rather than divide: the ratio test is one compare
		severe = ({10'h000, s.errs} * 34'(SES_RATIO)) >
			{10'h000, s.bits};
		loc_inc = '0;
		loc_inc.errored_second      = s.crc_seen;
		loc_inc.severe_error_second = severe;
		loc_inc.bursty_error_second = (s.errs != '0) & ~severe;
		loc_inc.unavailable_second  = uas_now;
		loc_inc.packet_loss_second  = ~s.rx_seen;
		loc_inc.frame_loss          = s.lof_seen;
		// Test outranks sync loss, which outranks error rate
		if (s.loop_seen) begin
			loc_code = SPM_CODE_TEST;
		end else if (s.sync_seen) begin
			loc_code = SPM_CODE_SYNC;
		end else if (severe) begin
			loc_code = SPM_CODE_EXC;
		end else begin
			loc_code = SPM_CODE_NONE;
		end
		// Far card's own packet-loss bit is never trusted here
		rem_inc = s.rx_seen ? spm_inc_t'(s.rx_byte[5:0]) : '0;
		rem_inc.packet_loss_second = 1'b0;
	end

	// ****************************************************************
	// Bank connections
	// ****************************************************************
	always_comb begin
		loc_if.tick     = tick;
		loc_if.hour_end = hour_end;
		loc_if.clr      = s.clr_loc;
		loc_if.inc      = loc_inc;
		loc_if.code     = loc_code;
		loc_if.qtr      = qtr;
		loc_if.rd_hour  = hour_of(reg_addr_in);
		loc_if.rd_field = field_of(reg_addr_in);
		rem_if.tick     = tick;
		rem_if.hour_end = hour_end;
		rem_if.clr      = s.clr_rem;
		rem_if.inc      = rem_inc;
		rem_if.code     = s.rx_seen ? spm_code_t'(s.rx_byte[7:6])
			: SPM_CODE_NONE;
		rem_if.qtr      = qtr;
		rem_if.rd_hour  = hour_of(reg_addr_in);
		rem_if.rd_field = field_of(reg_addr_in);
	end

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_s = s;
		next_s.clr_loc = 1'b0;
		next_s.clr_rem = 1'b0;
		next_s.tx_v    = 1'b0;
		next_s.rdata   = '0;

		// Accumulators restart on the tick; an event in that cycle
		// opens the new second instead of being lost
		if (sec_tick_in) begin
			next_s.crc_seen  = crc_err_in;
			next_s.bits      = ACC_W'(bit_valid_in);
			next_s.errs      = ACC_W'(bit_err_in);
			next_s.lof_seen  = lof_decl;
			next_s.sync_seen = sync_loss_in;
			next_s.loop_seen = loopback_in;
			next_s.rx_seen   = rx_mon_valid_in;
			next_s.peer      = s.rx_seen;
		end else begin
			next_s.crc_seen  = s.crc_seen | crc_err_in;
			next_s.bits      = s.bits + ACC_W'(bit_valid_in);
			next_s.errs      = s.errs + ACC_W'(bit_err_in);
			next_s.lof_seen  = s.lof_seen | lof_decl;
			next_s.sync_seen = s.sync_seen | sync_loss_in;
			next_s.loop_seen = s.loop_seen | loopback_in;
			next_s.rx_seen   = s.rx_seen | rx_mon_valid_in;
		end
		if (rx_mon_valid_in) begin
			next_s.rx_byte = rx_mon_data_in;
		end

		if (tick) begin
			next_s.sec = hour_end ? '0 : s.sec + 12'h001;
			case (s.av)
				SPM_AVAIL: begin
					if (!severe) begin
						next_s.run = '0;
					end else if (s.run == 4'(UAS_RUN - 1)) begin
						next_s.av  = SPM_UNAVAIL;
						next_s.run = '0;
					end else begin
						next_s.run = s.run + 4'h1;
					end
				end
				SPM_UNAVAIL: begin
					if (severe) begin
						next_s.run = '0;
					end else if (s.run == 4'(UAS_RUN - 1)) begin
						next_s.av  = SPM_AVAIL;
						next_s.run = '0;
					end else begin
						next_s.run = s.run + 4'h1;
					end
				end
				default: begin
					next_s.av  = SPM_AVAIL;
					next_s.run = '0;
				end
			endcase
			next_s.tx_v = 1'b1;
			next_s.tx_d = {loc_code, loc_inc};
			next_s.tx_d[1] = 1'b0;
		end

		// Register writes
		if (reg_wr_in && is_ctrl(reg_addr_in)) begin
			next_s.perf     = reg_wdata_in[CTRL_PERF];
			next_s.view_rem = reg_wdata_in[CTRL_VIEW];
			next_s.rate56   = reg_wdata_in[CTRL_R56];
			next_s.nchan    = reg_wdata_in[CTRL_NHI:CTRL_NLO];
			if (reg_wdata_in[CTRL_CLR]) begin
				next_s.clr_loc = ~reg_wdata_in[CTRL_VIEW];
				next_s.clr_rem = reg_wdata_in[CTRL_VIEW];
			end
		end

		// Register reads: data stand only in the following cycle
		if (reg_rd_in) begin
			case (reg_addr_in[11:10])
				RGN_LOCAL: begin
					next_s.rdata = 32'(loc_if.rd_data);
				end
				RGN_REMOTE: begin
					next_s.rdata = 32'(rem_if.rd_data);
				end
				default: begin
					if (is_ctrl(reg_addr_in)) begin
						next_s.rdata[CTRL_PERF] = s.perf;
						next_s.rdata[CTRL_VIEW] = s.view_rem;
						next_s.rdata[CTRL_R56]  = s.rate56;
						next_s.rdata[CTRL_NHI:CTRL_NLO] = s.nchan;
					end else if (reg_addr_in == OFS_STAT) begin
						next_s.rdata[3:0] = {s.peer, lof_level,
							uas_now, s.perf};
					end else if (reg_addr_in == OFS_RATE) begin
						next_s.rdata[15:0] = s.rate;
					end
				end
			endcase
		end

		// Usable rate: N channels less the monitoring overhead
		// A circuit too narrow for the overhead leaves nothing usable
		next_s.rate = (gross > 16'(MON_KBPS) && s.perf) ?
			gross - 16'(MON_KBPS) : (s.perf ? '0 : gross);
	end

	assign gross = 16'(s.nchan) * (s.rate56 ? 16'(RATE56_KBPS)
		: 16'(RATE64_KBPS));

	// ****************************************************************
	// Registers
	// ****************************************************************
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s <= '0;
			s.nchan <= NCHAN_RST;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************************************
	// Outputs
	// ****************************************************************
	assign reg_rdata_out      = s.rdata;
	assign tx_mon_valid_out   = s.tx_v;
	assign tx_mon_data_out    = s.tx_d;
	assign perf_active_out    = s.perf;
	assign user_rate_kbps_out = s.rate;
	assign unavailable_out    = uas_now;
	assign frame_loss_out     = lof_level;
endmodule // spm_monitor

// *** spm_monitor_assertions.sv ***
// Port checker for the performance monitor core
`timescale 1ns/100ps
module spm_monitor_assertions
	import spm_pkg::*;
#(
	parameter int LOF_SET = 25,
	parameter int LOF_CLR = 10
) (
	input wire logic        clk_sys_in,
	input wire logic        rst_n_in,
	input wire logic        sec_tick_in,
	input wire logic        sync_loss_in,
	input wire logic        out_of_frame_in,
	input wire logic [11:0] reg_addr_in,
	input wire logic        reg_rd_in,
	input wire logic [31:0] reg_rdata_out,
	input wire logic        tx_mon_valid_out,
	input wire logic [7:0]  tx_mon_data_out,
	input wire logic        perf_active_out,
	input wire logic        unavailable_out,
	input wire logic        frame_loss_out
);
	// ****************************************************************
	// Run length helpers
	// ****************************************************************
	int   loss_run;
	int   clean_run;
	logic loss;
	assign loss = sync_loss_in | out_of_frame_in;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			loss_run  <= 0;
			clean_run <= 0;
		end else begin
			loss_run  <= loss ? loss_run + 1 : 0;
			clean_run <= loss ? 0 : clean_run + 1;
		end
	end
	// ****************************************************************
	// Properties
	// ****************************************************************
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	AST_RDATA_IDLE: assert property (
		!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside its cycle");
	AST_STATUS_READ: assert property (
		reg_rd_in && reg_addr_in == OFS_STAT |=>
		reg_rdata_out[2:0] ==
		$past({frame_loss_out, unavailable_out, perf_active_out}))
		else $error("status word disagrees with outputs");
	AST_TX_AFTER_TICK: assert property (
		sec_tick_in && perf_active_out |=> tx_mon_valid_out)
		else $error("no monitor byte after tick");
	AST_TX_ONLY_TICK: assert property (
		tx_mon_valid_out |-> $past(sec_tick_in))
		else $error("monitor byte without tick");
	AST_TX_HOLD: assert property (
		!$past(sec_tick_in) |-> $stable(tx_mon_data_out))
		else $error("monitor byte changed between ticks");
	AST_NO_PLOSS_BIT: assert property (
		tx_mon_valid_out |-> !tx_mon_data_out[1])
		else $error("packet loss sent to far card");
	AST_UNAV_ON_TICK: assert property (
		$changed(unavailable_out) |-> $past(sec_tick_in))
		else $error("unavailable moved off a second boundary");
	AST_LOF_SET_MIN: assert property (
		$rose(frame_loss_out) |-> loss_run >= LOF_SET - 2)
		else $error("frame loss declared too early");
	AST_LOF_SET_MAX: assert property (
		loss_run == LOF_SET + 3 |-> frame_loss_out)
		else $error("frame loss not declared");
	AST_LOF_CLR_MIN: assert property (
		$fell(frame_loss_out) |-> clean_run >= LOF_CLR - 2)
		else $error("frame loss cleared too early");
endmodule // spm_monitor_assertions

bind spm_monitor spm_monitor_assertions #(.LOF_SET(LOF_SET), .LOF_CLR(LOF_CLR))
	spm_monitor_assertions_inst (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
	.sec_tick_in(sec_tick_in), .sync_loss_in(sync_loss_in),
	.out_of_frame_in(out_of_frame_in), .reg_addr_in(reg_addr_in),
	.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.tx_mon_valid_out(tx_mon_valid_out), .tx_mon_data_out(tx_mon_data_out),
	.perf_active_out(perf_active_out), .unavailable_out(unavailable_out),
	.frame_loss_out(frame_loss_out));

// *** spm_far_card.sv ***
// Behavioural far card answering on the monitoring channel
`timescale 1ns/100ps
module spm_far_card (
	input  wire logic       clk_sys_in,
	input  wire logic       rst_n_in,
	input  wire logic       tx_mon_valid_in,
	input  wire logic       mute_in,
	input  wire logic       slow_in,
	input  wire logic [7:0] report_in,
	output logic            rx_mon_valid_out,
	output logic      [7:0] rx_mon_data_out
);
	logic [2:0] wait_cnt;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wait_cnt <= 3'h0;
			rx_mon_valid_out <= 1'b0;
			rx_mon_data_out <= 8'h00;
		end else begin
			rx_mon_valid_out <= 1'b0;
			// Idle line toggles so a stale byte is never mistaken for data
			rx_mon_data_out <= ~rx_mon_data_out;
			if (tx_mon_valid_in) begin
				wait_cnt <= slow_in ? 3'h3 : 3'h1;
			end else if (wait_cnt != 3'h0) begin
				wait_cnt <= wait_cnt - 3'h1;
				if (wait_cnt == 3'h1 && !mute_in) begin
					rx_mon_valid_out <= 1'b1;
					rx_mon_data_out <= report_in;
				end
			end
		end
	end
endmodule // spm_far_card

// *** spm_monitor_bench.sv ***
// Self-checking bench for the performance monitor core
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; \
	$display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module spm_monitor_bench;
	import spm_pkg::*;
	logic        clk_sys_in = 1'b0;
	logic        rst_n_in, sec_tick_in, loopback_in, crc_err_in;
	logic        bit_valid_in, bit_err_in, sync_loss_in, out_of_frame_in;
	logic        rx_mon_valid_in, reg_wr_in, reg_rd_in, mute, slow;
	logic        tx_mon_valid_out, perf_active_out;
	logic        unavailable_out, frame_loss_out;
	logic [7:0]  rx_mon_data_in, tx_mon_data_out, report;
	logic [11:0] reg_addr_in;
	logic [31:0] reg_wdata_in, reg_rdata_out;
	logic [15:0] user_rate_kbps_out;
	logic [31:0] exp_l [6] = '{32'h1, 32'h3, 32'h1, 32'hc, 32'ha, 32'h1};
	int          n_fail, compares, s;
	always #25 clk_sys_in = ~clk_sys_in;
	spm_monitor #(.LOF_SET(25), .LOF_CLR(10)) spm_monitor_inst (
		.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
		.sec_tick_in(sec_tick_in), .loopback_in(loopback_in),
		.crc_err_in(crc_err_in), .bit_valid_in(bit_valid_in),
		.bit_err_in(bit_err_in), .sync_loss_in(sync_loss_in),
		.out_of_frame_in(out_of_frame_in), .rx_mon_valid_in(rx_mon_valid_in),
		.rx_mon_data_in(rx_mon_data_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
		.tx_mon_valid_out(tx_mon_valid_out), .tx_mon_data_out(tx_mon_data_out),
		.perf_active_out(perf_active_out),
		.user_rate_kbps_out(user_rate_kbps_out),
		.unavailable_out(unavailable_out), .frame_loss_out(frame_loss_out));
	spm_far_card spm_far_card_inst (.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in), .tx_mon_valid_in(tx_mon_valid_out),
		.mute_in(mute), .slow_in(slow), .report_in(report),
		.rx_mon_valid_out(rx_mon_valid_in), .rx_mon_data_out(rx_mon_data_in));
	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic close_out();
		if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [11:0] ca(input logic [11:0] b, input int h,
		input int f);
		return b | 12'(h << 5) | 12'(f << 2);
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic rd_chk(input logic [11:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hffffffff);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge clk_sys_in);
		reg_rd_in <= 1'b0;
		#1;
		`CHK(reg_rdata_out & m, e)
	endtask
	// Errors land in the current second, then the tick closes it
	task automatic sec(input bit crc, input int e, input int bits);
		for (int i = 0; i < bits; i++) begin
			@(posedge clk_sys_in);
			bit_valid_in <= 1'b1;
			bit_err_in <= (i < e);
			crc_err_in <= crc && (i == 0);
		end
		@(posedge clk_sys_in);
		bit_valid_in <= 1'b0;
		bit_err_in <= 1'b0;
		crc_err_in <= 1'b0;
		sec_tick_in <= 1'b1;
		@(posedge clk_sys_in);
		sec_tick_in <= 1'b0;
		#1;
		`CHK(tx_mon_valid_out, 1'b1)
		repeat (4) @(posedge clk_sys_in);
		#1;
		`CHK(tx_mon_valid_out, 1'b0)
		s++;
	endtask
	// ****************************************************************
	// Scenarios
	// ****************************************************************
	task automatic t_rate();
		wr(OFS_CTRL, 32'h38);
		`CHK(user_rate_kbps_out, 16'ha8)
		`CHK(perf_active_out, 1'b0)
		wr(OFS_CTRL, 32'h39);
		`CHK(user_rate_kbps_out, 16'ha0)
		`CHK(perf_active_out, 1'b1)
		rd_chk(OFS_RATE, 32'ha0);
		wr(OFS_CTRL, 32'h11);
		`CHK(user_rate_kbps_out, 16'h38)
	endtask
	task automatic t_seconds();
		report = 8'h20;
		sec(1'b1, 1, 1000);
		`CHK(tx_mon_data_out[5:2], 4'b1001)
		report = 8'h00;
		mute = 1'b1;
		sec(1'b0, 1, 999);
		`CHK(tx_mon_data_out[3:2], 2'b10)
		sec(1'b0, 0, 0);
		mute = 1'b0;
		slow = 1'b1;
		for (int i = 0; i < 10; i++) begin
			sec(1'b0, 1, 1);
			`CHK(unavailable_out, i == 9)
		end
		rd_chk(OFS_STAT, 32'hb);
		for (int i = 0; i < 10; i++) begin
			sec(1'b0, 0, 0);
			`CHK(unavailable_out, i != 9)
			`CHK(tx_mon_data_out[4], 1'b1)
		end
		slow = 1'b0;
	endtask
	task automatic t_frame();
		@(posedge clk_sys_in) out_of_frame_in <= 1'b1;
		repeat (20) @(posedge clk_sys_in);
		out_of_frame_in <= 1'b0;
		repeat (3) @(posedge clk_sys_in);
		sync_loss_in <= 1'b1;
		#1;
		`CHK(frame_loss_out, 1'b0)
		repeat (30) @(posedge clk_sys_in);
		sync_loss_in <= 1'b0;
		#1;
		`CHK(frame_loss_out, 1'b1)
		repeat (7) @(posedge clk_sys_in);
		#1;
		`CHK(frame_loss_out, 1'b1)
		repeat (5) @(posedge clk_sys_in);
		#1;
		`CHK(frame_loss_out, 1'b0)
		sec(1'b0, 0, 0);
		`CHK(tx_mon_data_out[0], 1'b1)
	endtask
	task automatic t_hour();
		while (s < 1000) sec(1'b0, 0, 0);
		@(posedge clk_sys_in) loopback_in <= 1'b1;
		sec(1'b0, 0, 0);
		`CHK(tx_mon_data_out[7:6], SPM_CODE_TEST)
		@(posedge clk_sys_in) loopback_in <= 1'b0;
		while (s < 1900) sec(1'b0, 0, 0);
		@(posedge clk_sys_in) sync_loss_in <= 1'b1;
		repeat (3) @(posedge clk_sys_in);
		sync_loss_in <= 1'b0;
		sec(1'b0, 0, 0);
		`CHK(tx_mon_data_out[7:6], SPM_CODE_SYNC)
		while (s < 2800) sec(1'b0, 0, 0);
		sec(1'b0, 1, 1);
		`CHK(tx_mon_data_out[7:6], SPM_CODE_EXC)
		while (s < 3599) sec(1'b0, 0, 0);
		rd_chk(ca(12'h400, 0, 3), 32'hc);
		sec(1'b0, 0, 0);
		rd_chk(ca(12'h400, 0, 3), 32'h0);
		for (int f = 0; f < 6; f++)
			rd_chk(ca(12'h400, 1, f), exp_l[f]);
		rd_chk(ca(12'h400, 1, 6), 32'he7);
		rd_chk(ca(12'h800, 1, 5), 32'h1);
		rd_chk(ca(12'h800, 1, 1), 32'h0);
		rd_chk(ca(12'h400, 25, 0), 32'h0);
	endtask
	task automatic t_clear();
		wr(OFS_CTRL, 32'h15);
		rd_chk(ca(12'h400, 1, 3), 32'h0);
		rd_chk(ca(12'h800, 1, 5), 32'h1);
		wr(OFS_CTRL, 32'h17);
		rd_chk(ca(12'h800, 1, 5), 32'h0);
		rd_chk(OFS_CTRL, 32'h13);
		wr(OFS_CTRL, 32'h10);
		`CHK(perf_active_out, 1'b0)
		`CHK(user_rate_kbps_out, 16'h40)
		@(posedge clk_sys_in) sec_tick_in <= 1'b1;
		@(posedge clk_sys_in) sec_tick_in <= 1'b0;
		#1;
		`CHK(tx_mon_valid_out, 1'b0)
	endtask
	// ****************************************************************
	// Main sequence
	// ****************************************************************
	initial begin
		{rst_n_in, sec_tick_in, loopback_in, crc_err_in, bit_valid_in} = '0;
		{bit_err_in, sync_loss_in, out_of_frame_in, reg_wr_in} = '0;
		{reg_rd_in, mute, slow, report, reg_addr_in, reg_wdata_in} = '0;
		repeat (8) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		repeat (2) @(posedge clk_sys_in);
		#1;
		`CHK(user_rate_kbps_out, 16'h40)
		rd_chk(OFS_CTRL, 32'h10);
		rd_chk(12'h00c, 32'h0);
		t_rate();
		t_seconds();
		t_frame();
		t_hour();
		t_clear();
		close_out();
	end
	initial begin
		repeat (40000) @(posedge clk_sys_in);
		n_fail++;
		close_out();
	end
endmodule // spm_monitor_bench
